// File: core/eoi_pkg.sv
// Purpose: Shared constants for the E1 transmit overhead inserter
// Assumes: 250 MHz clock, one port per instance
// Notes:   Offsets are byte addresses of port 0
package eoi_pkg;

    // ************************************
    // Register map
    // ************************************
    localparam int          NUM_RW      = 11;
    localparam int          NUM_REGS    = 12;
    localparam logic [11:0] PORT_STRIDE = 12'h200;
    localparam logic [11:0] OFS_FIRST   = 12'h164;
    localparam logic [11:0] OFS_SPARE7  = 12'h16C;

    // Register indices, byte address = OFS_FIRST + index
    localparam logic [3:0] REG_ALIGN    = 4'h0;
    localparam logic [3:0] REG_NONALIGN = 4'h1;
    localparam logic [3:0] REG_INTL_EVN = 4'h2;
    localparam logic [3:0] REG_INTL_ODD = 4'h3;
    localparam logic [3:0] REG_ALARM    = 4'h4;
    localparam logic [3:0] REG_SPARE4   = 4'h5;
    localparam logic [3:0] REG_CTRL     = 4'hA;
    localparam logic [3:0] REG_STATUS   = 4'hB;

    // Reset values: align pattern and fixed non-align one
    localparam logic [7:0] REG_RST [NUM_RW] = '{
        8'h1B, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // ************************************
    // Field positions
    // ************************************
    localparam int CTL_INTL_ALIGN = 7;
    localparam int CTL_INTL_NON   = 6;
    localparam int CTL_ALARM      = 5;
    localparam int WORD_INTL      = 7;
    localparam int WORD_FIXED_ONE = 6;
    localparam int WORD_ALARM     = 5;

    // ************************************
    // Timing
    // ************************************
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          ALIGN_WIN_NS  = 250000;
    localparam int          MF_WIN_NS     = 2000000;
    localparam int          ALIGN_WIN_CYC = ALIGN_WIN_NS / CLK_PERIOD_NS;
    localparam int          MF_WIN_CYC    = MF_WIN_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  LAST_BIT      = 8'hFF;
    localparam logic [3:0]  LAST_FRAME    = 4'hF;

    // Hit flag and register index for a host address
    function automatic logic [4:0] reg_decode(logic [11:0] addr, logic [11:0] base);
        logic [11:0] off;
        off = addr - base - OFS_FIRST;
        return {off < 12'(NUM_REGS), off[3:0]};
    endfunction : reg_decode

endpackage : eoi_pkg

// File: core/eoi_ovh_if.sv
// Purpose: Sampled overhead words and line position to the bit selector
// Assumes: Same clock as the owning port
// Notes:   Selector answers combinationally
`timescale 1ns/1ps
interface eoi_ovh_if (input wire logic clock, input wire logic srst);
    logic [7:0]      alignWord;
    logic [7:0]      nonalignWord;
    logic [7:0]      intlEven;
    logic [7:0]      intlOdd;
    logic [7:0]      remoteAlarm;
    logic [4:0][7:0] spare;
    logic [7:0]      insertCtrl;
    logic            intlOverride;
    logic [2:0]      ts0Bit;
    logic [3:0]      frameNum;
    logic            serialBit;
    logic            ovhBit;

    modport owner (input clock, srst, ovhBit, output alignWord, nonalignWord,
        intlEven, intlOdd, remoteAlarm, spare, insertCtrl, intlOverride,
        ts0Bit, frameNum, serialBit);
    modport sel (input clock, srst, alignWord, nonalignWord, intlEven, intlOdd,
        remoteAlarm, spare, insertCtrl, intlOverride, ts0Bit, frameNum,
        serialBit, output ovhBit);
endinterface : eoi_ovh_if

// File: core/eoi_bit_select.sv
// Purpose: Picks the outgoing bit for each slot-zero position
// Assumes: Register words go out most significant bit first
// Notes:   Purely combinational
`timescale 1ns/1ps
module eoi_bit_select import eoi_pkg::*; (
    // Overhead words and position
    eoi_ovh_if.sel ovh
);

    // ************************************
    // Position decode
    // ************************************
    logic [2:0] mfSlot;
    logic [2:0] regBit;
    logic [2:0] spareIdx;
    logic       oddFrame;
    logic       intlAlign;
    logic       intlNon;
    logic       evenBit;
    logic       oddBit;

    assign mfSlot   = ovh.frameNum[3:1];
    assign oddFrame = ovh.frameNum[0];
    assign regBit   = ~ovh.ts0Bit;
    assign spareIdx = 3'(ovh.ts0Bit - 3'h3);

    // ************************************
    // International bits
    // ************************************
    // Override wins, then even- or odd-frame intl register
    assign intlAlign = ovh.intlOverride ? ovh.serialBit :
        ovh.insertCtrl[CTL_INTL_ALIGN] ? ovh.intlEven[mfSlot] : ovh.alignWord[WORD_INTL];
    assign intlNon = ovh.intlOverride ? ovh.serialBit :
        ovh.insertCtrl[CTL_INTL_NON] ? ovh.intlOdd[mfSlot] : ovh.nonalignWord[WORD_INTL];

    // ************************************
    // Frame words
    // ************************************
    // Align pattern from the align word
    assign evenBit = (ovh.ts0Bit == 3'h0) ? intlAlign : ovh.alignWord[regBit];
    assign oddBit = (ovh.ts0Bit == 3'h0) ? intlNon :
        (ovh.ts0Bit == 3'h1) ? ovh.nonalignWord[WORD_FIXED_ONE] :
        (ovh.ts0Bit == 3'h2) ? (ovh.insertCtrl[CTL_ALARM] ?
            ovh.remoteAlarm[mfSlot] : ovh.nonalignWord[WORD_ALARM]) :
        (ovh.insertCtrl[regBit] ? ovh.spare[spareIdx][mfSlot] : ovh.nonalignWord[regBit]);
    assign ovh.ovhBit = oddFrame ? oddBit : evenBit;

    // ************************************
    // Checks
    // ************************************
    intl_override_a :
        assert property (@(posedge ovh.clock) disable iff (ovh.srst)
            ovh.intlOverride && ovh.ts0Bit == 3'h0 |-> ovh.ovhBit == ovh.serialBit)
        else $error("intl bit not taken from serial input");
    spare_insert_a :
        assert property (@(posedge ovh.clock) disable iff (ovh.srst)
            oddFrame && ovh.ts0Bit == 3'h7 && ovh.insertCtrl[0]
            |-> ovh.ovhBit == ovh.spare[4][mfSlot])
        else $error("last spare bit not inserted");
    spare_bypass_a :
        assert property (@(posedge ovh.clock) disable iff (ovh.srst)
            oddFrame && ovh.ts0Bit == 3'h3 && !ovh.insertCtrl[4]
            |-> ovh.ovhBit == ovh.nonalignWord[4])
        else $error("first spare bit not from non-align word");
    alarm_insert_a :
        assert property (@(posedge ovh.clock) disable iff (ovh.srst)
            oddFrame && ovh.ts0Bit == 3'h2 && ovh.insertCtrl[CTL_ALARM]
            |-> ovh.ovhBit == ovh.remoteAlarm[mfSlot])
        else $error("alarm register not inserted");
    intl_even_a :
        assert property (@(posedge ovh.clock) disable iff (ovh.srst)
            !oddFrame && ovh.ts0Bit == 3'h0 && !ovh.intlOverride
            && ovh.insertCtrl[CTL_INTL_ALIGN] |-> ovh.ovhBit == ovh.intlEven[mfSlot])
        else $error("even-frame intl bit wrong");

endmodule : eoi_bit_select

// File: core/eoi_tx_overhead.sv
// Purpose: E1 transmit slot-zero overhead insertion for one port
// Assumes: Host strobes and line tick are on the framer clock
// Notes:   Instantiate once per port with its index
//
// How it works
// - Align and non-align words are sampled when the align flag sets.
// - Host rewrites within 250 us, else old words go out again.
// - Stored align words repeat, so fixed patterns need one write.
// - Serial source, CRC-4 or auto E-bit overrides register intl bit.
// - Eight multiframe registers feed intl, alarm and spare bits under control.
// - Multiframe registers sampled at multiframe event; 2 ms to update.
// - Align word holds pattern 1101100 in bits 0-6, intl in bit 7.
// - Non-align word: spares in bits 0-4, alarm 5, one 6, intl 7.
// - Even intl register bit n feeds frame 2n.
// - Odd intl register bit n feeds frame 2n+1.
// - Alarm register bit n feeds the alarm of frame 2n+1.
// - Each spare register bit n feeds its bit in frame 2n+1.
// - Control bits 0-4 enable the last through first spare registers.
// - Control bit 5 enables the alarm register.
// - Control bits 6 and 7 enable odd and even intl registers.
// - Each port's copy sits at port base plus 200h per port.
`timescale 1ns/1ps
module eoi_tx_overhead import eoi_pkg::*; #(
    parameter int PORT_INDEX       = 0,
    parameter int ALIGN_WIN_CYCLES = ALIGN_WIN_CYC,
    parameter int MF_WIN_CYCLES    = MF_WIN_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Host register port
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    // Framing mode
    input  wire logic        intlFromSerial,
    input  wire logic        crc4Mode,
    input  wire logic        autoEbitEn,
    // Transmit line stream
    input  wire logic        lineBitTick,
    input  wire logic        lineMfSync,
    input  wire logic        txSerialData,
    output logic             txLineData,
    // Status events
    output logic             txAlignFrameEvt,
    output logic             txMultiframeEvt,
    output logic             alignUpdWindow,
    output logic             mfUpdWindow
);

    // ************************************
    // Port base
    // ************************************
    // Per-port stride
    localparam logic [11:0] PORT_BASE = 12'(PORT_INDEX * int'(PORT_STRIDE));

    // ************************************
    // Declarations
    // ************************************
    logic [7:0]  regs_ff [NUM_RW];
    logic [7:0]  alignSh_ff;
    logic [7:0]  nonalignSh_ff;
    logic [7:0]  mfSh_ff [8];
    logic [7:0]  bitCnt_ff;
    logic [3:0]  frameCnt_ff;
    logic [19:0] alignWinCnt_ff;
    logic [19:0] mfWinCnt_ff;
    logic        alignWin_ff;
    logic        mfWin_ff;
    logic        alignEvt_ff;
    logic        mfEvt_ff;
    logic        lineData_ff;
    logic [7:0]  rdData_ff;

    logic [4:0]  decode;
    logic        addrHit;
    logic [3:0]  regIdx;
    logic        wrHit;
    logic [7:0]  rdValue;
    logic [7:0]  statusWord;
    logic [7:0]  curBit;
    logic [3:0]  curFrame;
    logic        frameEnd;
    logic        alignEvt;
    logic        mfEvt;
    logic        inTs0;
    logic [7:0]  nxt_bitCnt;
    logic [3:0]  nxt_frameCnt;
    logic [19:0] nxt_alignWinCnt;
    logic [19:0] nxt_mfWinCnt;
    logic        nxt_lineData;

    eoi_ovh_if ovh (.clock(clock), .srst(srst));

    // ************************************
    // Address decode
    // ************************************
    assign decode  = reg_decode(regAddr, PORT_BASE);
    assign addrHit = decode[4];
    assign regIdx  = decode[3:0];
    assign wrHit   = regWr && addrHit && regIdx < REG_STATUS;

    // ************************************
    // Host registers
    // ************************************
    // Writable words with pattern reset
    always_ff @(posedge clock) begin
        if (srst) begin
            regs_ff <= REG_RST;
        end else if (wrHit) begin
            regs_ff[regIdx] <= regWrData;
        end
    end

    // Position and update windows for the host
    assign statusWord = {alignWin_ff, mfWin_ff, 2'b00, frameCnt_ff};
    assign rdValue = !addrHit ? 8'h00 :
        (regIdx == REG_STATUS) ? statusWord : regs_ff[regIdx];

    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_ff <= 8'h00;
        end else if (regRd) begin
            rdData_ff <= rdValue;
        end
    end

    assign regRdData = rdData_ff;

    // ************************************
    // Line position
    // ************************************
    assign curBit   = lineMfSync ? 8'h00 : bitCnt_ff;
    assign curFrame = lineMfSync ? 4'h0 : frameCnt_ff;
    assign frameEnd = lineBitTick && curBit == LAST_BIT;
    assign alignEvt = frameEnd && curFrame[0];
    assign mfEvt    = frameEnd && curFrame == LAST_FRAME;
    assign inTs0    = curBit[7:3] == 5'h00;

    assign nxt_bitCnt   = lineBitTick ? 8'(curBit + 8'h01) : bitCnt_ff;
    assign nxt_frameCnt = frameEnd ? 4'(curFrame + 4'h1) :
        lineBitTick ? curFrame : frameCnt_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            bitCnt_ff   <= 8'h00;
            frameCnt_ff <= 4'h0;
        end else begin
            bitCnt_ff   <= nxt_bitCnt;
            frameCnt_ff <= nxt_frameCnt;
        end
    end

    // ************************************
    // Frame-pair sampling
    // ************************************
    // Load at flag, hold otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            alignSh_ff    <= REG_RST[REG_ALIGN];
            nonalignSh_ff <= REG_RST[REG_NONALIGN];
        end else if (alignEvt) begin
            alignSh_ff    <= regs_ff[REG_ALIGN];
            nonalignSh_ff <= regs_ff[REG_NONALIGN];
        end
    end

    // ************************************
    // Multiframe sampling
    // ************************************
    // Load eight words at multiframe event
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                mfSh_ff[i] <= 8'h00;
            end
        end else if (mfEvt) begin
            for (int i = 0; i < 8; i++) begin
                mfSh_ff[i] <= regs_ff[int'(REG_INTL_EVN) + i];
            end
        end
    end

    // ************************************
    // Update windows
    // ************************************
    // Host update time after each flag
    assign nxt_alignWinCnt = alignEvt ? 20'(ALIGN_WIN_CYCLES) :
        (alignWinCnt_ff != 20'h00000) ? 20'(alignWinCnt_ff - 20'h00001) : alignWinCnt_ff;
    assign nxt_mfWinCnt = mfEvt ? 20'(MF_WIN_CYCLES) :
        (mfWinCnt_ff != 20'h00000) ? 20'(mfWinCnt_ff - 20'h00001) : mfWinCnt_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            alignWinCnt_ff <= 20'h00000;
            mfWinCnt_ff    <= 20'h00000;
            alignWin_ff    <= 1'b0;
            mfWin_ff       <= 1'b0;
        end else begin
            alignWinCnt_ff <= nxt_alignWinCnt;
            mfWinCnt_ff    <= nxt_mfWinCnt;
            alignWin_ff    <= nxt_alignWinCnt != 20'h00000;
            mfWin_ff       <= nxt_mfWinCnt != 20'h00000;
        end
    end

    assign alignUpdWindow = alignWin_ff;
    assign mfUpdWindow    = mfWin_ff;

    // ************************************
    // Status events
    // ************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            alignEvt_ff <= 1'b0;
            mfEvt_ff    <= 1'b0;
        end else begin
            alignEvt_ff <= alignEvt;
            mfEvt_ff    <= mfEvt;
        end
    end

    assign txAlignFrameEvt = alignEvt_ff;
    assign txMultiframeEvt = mfEvt_ff;

    // ************************************
    // Bit selector
    // ************************************
    assign ovh.alignWord    = alignSh_ff;
    assign ovh.nonalignWord = nonalignSh_ff;
    assign ovh.intlEven     = mfSh_ff[0];
    assign ovh.intlOdd      = mfSh_ff[1];
    assign ovh.remoteAlarm  = mfSh_ff[2];
    assign ovh.spare        = {mfSh_ff[7], mfSh_ff[6], mfSh_ff[5], mfSh_ff[4], mfSh_ff[3]};
    assign ovh.insertCtrl   = regs_ff[REG_CTRL];
    assign ovh.intlOverride = intlFromSerial || crc4Mode || autoEbitEn;
    assign ovh.ts0Bit       = curBit[2:0];
    assign ovh.frameNum     = curFrame;
    assign ovh.serialBit    = txSerialData;

    eoi_bit_select u_select (
        .ovh (ovh.sel)
    );

    // ************************************
    // Line output
    // ************************************
    // Slot zero from selector, rest from serial
    assign nxt_lineData = !lineBitTick ? lineData_ff :
        inTs0 ? ovh.ovhBit : txSerialData;

    always_ff @(posedge clock) begin
        if (srst) begin
            lineData_ff <= 1'b0;
        end else begin
            lineData_ff <= nxt_lineData;
        end
    end

    assign txLineData = lineData_ff;

    // ************************************
    // Checks
    // ************************************
    // Align shadow load
    align_load_a :
        assert property (@(posedge clock) disable iff (srst)
            alignEvt |=> alignSh_ff == $past(regs_ff[REG_ALIGN])
                && nonalignSh_ff == $past(regs_ff[REG_NONALIGN]))
        else $error("align words not sampled at flag");

    align_hold_a :
        assert property (@(posedge clock) disable iff (srst)
            !alignEvt |=> $stable(alignSh_ff) && $stable(nonalignSh_ff))
        else $error("align words changed between flags");

    mf_load_a :
        assert property (@(posedge clock) disable iff (srst)
            mfEvt |=> mfSh_ff[7] == $past(regs_ff[REG_SPARE4 + 4'h4])
                && mfSh_ff[0] == $past(regs_ff[REG_INTL_EVN]))
        else $error("multiframe words not sampled");

    mf_flag_a :
        assert property (@(posedge clock) disable iff (srst)
            mfEvt |-> alignEvt ##1 txMultiframeEvt && txAlignFrameEvt)
        else $error("multiframe flag out of step");

    port_decode_a :
        assert property (@(posedge clock) disable iff (srst)
            regWr && regAddr == 12'(PORT_BASE + OFS_SPARE7)
            |=> regs_ff[4'h8] == $past(regWrData))
        else $error("port register write missed");

    align_reset_a :
        assert property (@(posedge clock)
            srst |=> regs_ff[REG_ALIGN] == 8'h1B && alignSh_ff[6:0] == 7'h1B)
        else $error("align pattern not at reset value");

    align_win_a :
        assert property (@(posedge clock) disable iff (srst)
            alignEvt |=> alignUpdWindow [*4])
        else $error("update window not open after flag");

    fixed_one_a :
        assert property (@(posedge clock) disable iff (srst)
            lineBitTick && inTs0 && curFrame[0] && curBit[2:0] == 3'h1
            |=> txLineData == $past(nonalignSh_ff[WORD_FIXED_ONE]))
        else $error("non-align fixed bit wrong");

    align_evt_c : cover property (@(posedge clock) disable iff (srst) alignEvt);
    mf_evt_c    : cover property (@(posedge clock) disable iff (srst) mfEvt);
    ctrl_wr_c   : cover property (@(posedge clock) disable iff (srst)
        wrHit && regIdx == REG_CTRL ##1 inTs0 && lineBitTick);
    unmapped_c  : cover property (@(posedge clock) disable iff (srst) regRd && !addrHit);

endmodule : eoi_tx_overhead

// File: bench/eoi_line_model.sv
// Purpose: E1 line side: bit ticks, multiframe sync and serial data
// Assumes: One bit tick every two clocks
// Notes:   Serial data is a fresh random bit every cycle, so it can repeat
`timescale 1ns/1ps
module eoi_line_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Line stream
    output logic      lineBitTick,
    output logic      lineMfSync,
    output logic      txSerialData
);
    logic [12:0] cnt_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_ff       <= 13'h0000;
            lineBitTick  <= 1'b0;
            lineMfSync   <= 1'b0;
            txSerialData <= 1'b0;
        end else begin
            cnt_ff       <= cnt_ff + 13'h0001;
            lineBitTick  <= ~cnt_ff[0];
            // Sync on bit 0 of frame 0, every 4096 bits
            lineMfSync   <= (cnt_ff == 13'h0000);
            txSerialData <= 1'($urandom);
        end
    end
endmodule : eoi_line_model

// File: bench/eoi_tx_overhead_tb.sv
// Purpose: Self-checking bench for the overhead inserter
// Assumes: Port 3, shortened update windows
// Notes:   A shadow model predicts every slot-zero bit
`timescale 1ns/1ps
module eoi_tx_overhead_tb import eoi_pkg::*; ;
    localparam int PORT = 3;
    localparam int AW   = 20;
    localparam int MW   = 40;
    logic        clock, srst, regWr, regRd, intlFromSerial, crc4Mode, autoEbitEn;
    logic [11:0] regAddr, curM, nxtM;
    logic [7:0]  regWrData, regRdData;
    logic        lineBitTick, lineMfSync, txSerialData, txLineData;
    logic        txAlignFrameEvt, txMultiframeEvt, alignUpdWindow, mfUpdWindow;
    logic        rdD, pD, eA, eM, chkOn;
    logic [7:0]  rg [NUM_RW];
    logic [7:0]  sh [NUM_RW];
    logic        bitQ [$];
    logic [7:0]  rdQ [$];
    int          n_mismatch, cmp_count, aC, mC;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    eoi_tx_overhead #(.PORT_INDEX(PORT), .ALIGN_WIN_CYCLES(AW), .MF_WIN_CYCLES(MW)) i_dut (
        .clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .intlFromSerial(intlFromSerial), .crc4Mode(crc4Mode), .autoEbitEn(autoEbitEn),
        .lineBitTick(lineBitTick), .lineMfSync(lineMfSync), .txSerialData(txSerialData),
        .txLineData(txLineData), .txAlignFrameEvt(txAlignFrameEvt),
        .txMultiframeEvt(txMultiframeEvt), .alignUpdWindow(alignUpdWindow),
        .mfUpdWindow(mfUpdWindow));

    eoi_line_model i_line (.clock(clock), .srst(srst), .lineBitTick(lineBitTick),
        .lineMfSync(lineMfSync), .txSerialData(txSerialData));

    // ************************************
    // Model, driver and monitor
    // ************************************
    function automatic logic [11:0] adr(int i);
        return 12'(PORT * 'h200) + OFS_FIRST + 12'(i);
    endfunction : adr

    function automatic logic expBit(logic [11:0] c, logic s);
        logic       od;
        logic [2:0] p;
        logic [2:0] n;
        logic [7:0] w;
        od = c[8];
        p  = c[2:0];
        n  = c[11:9];
        w  = od ? sh[1] : sh[0];
        if (p == 3'h0) begin
            if (intlFromSerial | crc4Mode | autoEbitEn) return s;
            if (rg[REG_CTRL][od ? 6 : 7]) return sh[od ? 3 : 2][n];
            return w[7];
        end
        if (od && p >= 3'h2 && rg[REG_CTRL][7 - p]) return sh[p + 2][n];
        return w[7 - p];
    endfunction : expBit

    task automatic cmpBit(logic got, logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask : cmpBit

    task automatic cmpByte(logic [7:0] got, logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : cmpByte

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic bus(logic w, logic r, logic [11:0] a, logic [7:0] d);
        @(posedge clock);
        regWr     <= w;
        regRd     <= r;
        regAddr   <= a;
        regWrData <= d;
        if (r) rdQ.push_back(d);
    endtask : bus

    task automatic waitAt(logic [11:0] c);
        int k;
        for (k = 0; k < 9000; k++) begin
            @(posedge clock);
            if (curM == c) break;
        end
        if (k == 9000) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : waitAt

    always @(posedge clock) begin
        if (srst) begin
            nxtM = 12'h000;
            curM = 12'h000;
            chkOn = 1'b1;
            sh = REG_RST;
            pD <= 1'b0;
            eA <= 1'b0;
            eM <= 1'b0;
        end else begin
            pD <= 1'b0;
            eA <= 1'b0;
            eM <= 1'b0;
            if (lineBitTick) begin
                curM = lineMfSync ? 12'h000 : nxtM;
                nxtM = curM + 12'h001;
                // slot zero from overhead, rest from serial
                if (chkOn) begin
                    bitQ.push_back((curM[7:3] == 5'h00) ? expBit(curM, txSerialData)
                        : txSerialData);
                    pD <= 1'b1;
                end
                if (curM[8:0] == 9'h1FF) begin
                    sh[0] = rg[0];
                    sh[1] = rg[1];
                    eA <= 1'b1;
                end
                if (curM == 12'hFFF) begin
                    for (int i = 2; i < 10; i++) sh[i] = rg[i];
                    eM <= 1'b1;
                    chkOn = 1'b1;
                end
            end
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            rdD <= 1'b0;
            aC = 0;
            mC = 0;
        end else begin
            rdD <= regRd;
            if (rdD) cmpByte(regRdData, rdQ.pop_front());
            if (pD) cmpBit(txLineData, bitQ.pop_front());
            cmpBit(txAlignFrameEvt, eA);
            cmpBit(txMultiframeEvt, eM);
            aC = eA ? 1 : aC + int'(aC != 0);
            mC = eM ? 1 : mC + int'(mC != 0);
            if (eA) cmpBit(alignUpdWindow, 1'b1);
            if (aC == AW) cmpBit(alignUpdWindow, 1'b1);
            if (aC == AW + 1) cmpBit(alignUpdWindow, 1'b0);
            if (eM) cmpBit(mfUpdWindow, 1'b1);
            if (mC == MW) cmpBit(mfUpdWindow, 1'b1);
            if (mC == MW + 1) cmpBit(mfUpdWindow, 1'b0);
        end
    end

    initial begin
        logic [7:0] v;
        void'($urandom(91717));
        n_mismatch = 0;
        cmp_count = 0;
        srst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 12'h000;
        regWrData = 8'h00;
        intlFromSerial = 1'b0;
        crc4Mode = 1'b0;
        autoEbitEn = 1'b0;
        rg = REG_RST;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < NUM_RW; i++) bus(1'b0, 1'b1, adr(i), REG_RST[i]);
        bus(1'b0, 1'b1, OFS_FIRST, 8'h00);
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        // Rounds: full insert, serial, CRC-4, E-bit, random
        for (int r = 0; r < 5; r++) begin
            waitAt(12'hF0A);
            chkOn = 1'b0;
            intlFromSerial <= (r == 1);
            crc4Mode       <= (r == 2);
            autoEbitEn     <= (r == 3);
            for (int i = 0; i < NUM_RW; i++) begin
                v = 8'($urandom);
                if (i == 10 && r < 2) v = (r == 0) ? 8'hFF : 8'h00;
                rg[i] = v;
                bus(1'b1, 1'b0, adr(i), v);
            end
            bus(1'b1, 1'b0, OFS_FIRST, 8'hA5);
            // Status is read-only: frame 15, both windows closed
            bus(1'b1, 1'b0, adr(int'(REG_STATUS)), 8'hFF);
            bus(1'b0, 1'b1, adr(int'(REG_STATUS)), {4'h0, LAST_FRAME});
            for (int i = 0; i < NUM_RW; i++) bus(1'b0, 1'b1, adr(i), rg[i]);
            bus(1'b0, 1'b0, 12'h000, 8'h00);
        end
        waitAt(12'hF0A);
        print_verdict();
    end
endmodule : eoi_tx_overhead_tb
